// ==== design/fei_regs.svh ====
`ifndef FEI_REGS_SVH
`define FEI_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FEI_CTL_OFS      12'h038
`define FEI_DATA_OFS     12'h03C
`define FEI_ADDR_OFS     12'h040

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FEI_MASK_BIT     31
`define FEI_PEND_BIT     30
`define FEI_ADDR_LSB     2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FEI_MASK_RST     1'h1
`define FEI_DATA_RST     32'h0000_0000
`define FEI_ADDR_RST     30'h0000_0000

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define FEI_RESP_OKAY    2'h0
`define FEI_RESP_SLVERR  2'h2

`endif

// ==== design/fei_pkg.sv ====
package fei_pkg;

  // ----------------------------------------
  // Message sender states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    FEI_IDLE = 2'b01,
    FEI_SEND = 2'b10
  } fei_msg_state_e;

  // ----------------------------------------
  // Fault status flags seen by the block
  // ----------------------------------------
  typedef struct packed
  {
    logic primary_fault_overflow;
    logic advanced_fault_overflow;
    logic page_request_overflow;
    logic completion_timeout_flag;
    logic bad_completion_flag;
    logic inval_queue_error;
    logic advanced_log_first_record;
    logic primary_log_pending;
  } fei_flags_s;

  typedef logic [31:0] fei_word_t;

endpackage

// ==== design/fei_reg_if.sv ====
`timescale 1ns/1ps

interface fei_reg_if;
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_hit;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_hit;

  modport bus
  (
    output wr_en,
    output wr_addr,
    output wr_data,
    output wr_strb,
    output rd_addr,
    input  wr_hit,
    input  rd_data,
    input  rd_hit
  );

  modport regs
  (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  wr_strb,
    input  rd_addr,
    output wr_hit,
    output rd_data,
    output rd_hit
  );
endinterface

// ==== design/fei_axil.sv ====
`timescale 1ns/1ps
`include "fei_regs.svh"

module fei_axil
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [11:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [11:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  fei_reg_if.bus           rg
);
  import fei_pkg::*;

  logic        aw_held;
  logic [11:0] aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         aw_take  = i_awvalid && o_awready;
  wire         w_take   = i_wvalid && o_wready;
  wire         do_write = aw_held && w_held && !o_bvalid;
  wire         ar_take  = i_arvalid && o_arready;

  // ----------------------------------------
  // Write channels, taken in either order
  // ----------------------------------------
  assign o_awready  = !aw_held && !o_bvalid;
  assign o_wready   = !w_held && !o_bvalid;
  assign rg.wr_en   = do_write;
  assign rg.wr_addr = aw_addr;
  assign rg.wr_data = w_data;
  assign rg.wr_strb = w_strb;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end
    else if (aw_take)
    begin
      aw_held <= 1'b1;
      aw_addr <= i_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (w_take)
    begin
      w_held <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= `FEI_RESP_OKAY;
    end
    else if (do_write)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= rg.wr_hit ? `FEI_RESP_OKAY : `FEI_RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign o_arready  = !o_rvalid;
  assign rg.rd_addr = i_araddr;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `FEI_RESP_OKAY;
    end
    else if (ar_take)
    begin
      o_rvalid <= 1'b1;
      o_rdata  <= rg.rd_hit ? rg.rd_data : 32'h0000_0000;
      o_rresp  <= rg.rd_hit ? `FEI_RESP_OKAY : `FEI_RESP_SLVERR;
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end
endmodule

// ==== design/fei_msg.sv ====
`timescale 1ns/1ps

module fei_msg
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_pending,
  input  wire logic             i_mask,
  input  wire logic             i_hold,
  input  wire fei_pkg::fei_word_t i_addr,
  input  wire fei_pkg::fei_word_t i_data,
  input  wire logic             i_ready,
  output logic                  o_valid,
  output fei_pkg::fei_word_t    o_addr,
  output fei_pkg::fei_word_t    o_data,
  output logic                  o_sent
);
  import fei_pkg::*;

  fei_msg_state_e state;
  fei_msg_state_e next_state;
  wire            launch = i_pending && !i_mask && !i_hold;

  assign o_valid = (state == FEI_SEND) && !i_mask && i_pending;
  assign o_sent  = o_valid && i_ready;

  // ----------------------------------------
  // Launch, hand-over, withdraw on mask
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      FEI_IDLE: if (launch) next_state = FEI_SEND;
      FEI_SEND: if (o_sent || i_mask || !i_pending) next_state = FEI_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state <= FEI_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_addr <= 32'h0000_0000;
      o_data <= 32'h0000_0000;
    end
    else if (state == FEI_IDLE && launch)
    begin
      o_addr <= i_addr;
      o_data <= i_data;
    end
  end
endmodule

// ==== design/fei_top.sv ====
// What this block does
// - With the mask clear, an interrupt condition sends a message made of the data and address registers.
// - The mask bit, bit 31 of the control register, resets to 1 and software may set it.
// - No message ever leaves while the mask bit is set.
// - Every interrupt condition sets the read-only pending bit 30, including a primary fault record in primary logging.
// - In advanced logging, writing record 0 of the log and setting its flag is a condition.
// - Queue error, bad completion, completion timeout and page request overflow are conditions too.
// - A flag setting while any status flag is already set is not a new condition.
// - Pending stays set while the message is withheld by the mask or a transient hold.
// - Pending clears when the withheld message is finally sent.
// - In either logging mode, pending clears once all eight status flags, the primary flag included, are clear.
// - Data register bits 15:0 reset to zero and form the message payload.
// - Data bits 31:16 carry extended payload only when 32-bit data is supported, else read zero.
// - The message goes to the word-aligned address in bits 31:2 of the address register.
`timescale 1ns/1ps
`include "fei_regs.svh"

module fei_top
#(
  parameter int DATA_W = 32
)
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic [11:0] I_S_AXI_AWADDR,
  input  wire logic        I_S_AXI_AWVALID,
  output logic             O_S_AXI_AWREADY,
  input  wire logic [31:0] I_S_AXI_WDATA,
  input  wire logic [3:0]  I_S_AXI_WSTRB,
  input  wire logic        I_S_AXI_WVALID,
  output logic             O_S_AXI_WREADY,
  output logic [1:0]       O_S_AXI_BRESP,
  output logic             O_S_AXI_BVALID,
  input  wire logic        I_S_AXI_BREADY,
  input  wire logic [11:0] I_S_AXI_ARADDR,
  input  wire logic        I_S_AXI_ARVALID,
  output logic             O_S_AXI_ARREADY,
  output logic [31:0]      O_S_AXI_RDATA,
  output logic [1:0]       O_S_AXI_RRESP,
  output logic             O_S_AXI_RVALID,
  input  wire logic        I_S_AXI_RREADY,
  input  wire logic        I_ADV_LOG_MODE,
  input  wire logic        I_PRIMARY_LOG_PENDING,
  input  wire logic        I_ADVANCED_LOG_FIRST_RECORD,
  input  wire logic        I_INVAL_QUEUE_ERROR,
  input  wire logic        I_BAD_COMPLETION_FLAG,
  input  wire logic        I_COMPLETION_TIMEOUT_FLAG,
  input  wire logic        I_PAGE_REQUEST_OVERFLOW,
  input  wire logic        I_ADVANCED_FAULT_OVERFLOW,
  input  wire logic        I_PRIMARY_FAULT_OVERFLOW,
  input  wire logic        I_MSG_HOLD,
  output logic             O_MSG_VALID,
  input  wire logic        I_MSG_READY,
  output logic [31:0]      O_MSG_ADDR,
  output logic [31:0]      O_MSG_DATA,
  output logic             O_PENDING_FLAG,
  output logic             O_EVENT_MASK_BIT
);
  import fei_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (DATA_W != 16 && DATA_W != 32)
  begin : g_bad_width
    $error("DATA_W must be 16 or 32");
  end

  fei_reg_if  rg ();
  fei_flags_s flags;
  fei_flags_s flags_prev;
  fei_flags_s flags_rise;
  fei_flags_s cond_en;
  logic       event_mask_bit;
  logic       pending_flag;
  logic       next_pending;
  logic [31:0] msg_data_reg;
  logic [29:0] msg_addr_reg;
  logic       msg_sent;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  fei_axil u_axil
  (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RST),
    .i_awaddr  (I_S_AXI_AWADDR),
    .i_awvalid (I_S_AXI_AWVALID),
    .o_awready (O_S_AXI_AWREADY),
    .i_wdata   (I_S_AXI_WDATA),
    .i_wstrb   (I_S_AXI_WSTRB),
    .i_wvalid  (I_S_AXI_WVALID),
    .o_wready  (O_S_AXI_WREADY),
    .o_bresp   (O_S_AXI_BRESP),
    .o_bvalid  (O_S_AXI_BVALID),
    .i_bready  (I_S_AXI_BREADY),
    .i_araddr  (I_S_AXI_ARADDR),
    .i_arvalid (I_S_AXI_ARVALID),
    .o_arready (O_S_AXI_ARREADY),
    .o_rdata   (O_S_AXI_RDATA),
    .o_rresp   (O_S_AXI_RRESP),
    .o_rvalid  (O_S_AXI_RVALID),
    .i_rready  (I_S_AXI_RREADY),
    .rg        (rg.bus)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire wr_ctl  = rg.wr_en && rg.wr_addr == `FEI_CTL_OFS;
  wire wr_data = rg.wr_en && rg.wr_addr == `FEI_DATA_OFS;
  wire wr_addr = rg.wr_en && rg.wr_addr == `FEI_ADDR_OFS;
  wire rd_ctl  = rg.rd_addr == `FEI_CTL_OFS;
  wire rd_data = rg.rd_addr == `FEI_DATA_OFS;
  wire rd_addr = rg.rd_addr == `FEI_ADDR_OFS;

  assign rg.wr_hit = rg.wr_addr == `FEI_CTL_OFS || rg.wr_addr == `FEI_DATA_OFS
                     || rg.wr_addr == `FEI_ADDR_OFS;
  assign rg.rd_hit = rd_ctl || rd_data || rd_addr;

  // ----------------------------------------
  // Register read views
  // ----------------------------------------
  wire [31:0] ctl_view  = {event_mask_bit, pending_flag, 30'h0000_0000};
  wire [31:0] data_view = msg_data_reg;
  wire [31:0] addr_view = {msg_addr_reg, 2'h0};

  assign rg.rd_data = rd_ctl  ? ctl_view  :
                      rd_data ? data_view :
                      rd_addr ? addr_view : 32'h0000_0000;

  // ----------------------------------------
  // Control register: mask only
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      event_mask_bit <= `FEI_MASK_RST;
    else if (wr_ctl && rg.wr_strb[3])
      event_mask_bit <= rg.wr_data[`FEI_MASK_BIT];
  end

  // ----------------------------------------
  // Data register per byte
  // ----------------------------------------
  for (genvar b = 0; b < 4; b++)
  begin : g_byte
    if (b * 8 < DATA_W)
    begin : g_live
      logic [7:0] byte_q;

      always_ff @(posedge I_CORE_CLK or posedge I_RST)
      begin
        if (I_RST)
          byte_q <= 8'(`FEI_DATA_RST >> (b * 8));
        else if (wr_data && rg.wr_strb[b])
          byte_q <= rg.wr_data[b*8 +: 8];
      end

      assign msg_data_reg[b*8 +: 8] = byte_q;
    end
    else
    begin : g_zero
      assign msg_data_reg[b*8 +: 8] = 8'h00;
    end
  end

  // ----------------------------------------
  // Address register, low two bits fixed
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      msg_addr_reg <= `FEI_ADDR_RST;
    else if (wr_addr)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (rg.wr_strb[b])
          msg_addr_reg <= next_addr(msg_addr_reg, rg.wr_data, rg.wr_strb);
      end
    end
  end

  function automatic logic [29:0] next_addr(logic [29:0] cur, logic [31:0] wd, logic [3:0] st);
    logic [31:0] full;
    full = {cur, 2'h0};
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
        full[b*8 +: 8] = wd[b*8 +: 8];
    end
    return full[31:`FEI_ADDR_LSB];
  endfunction

  // ----------------------------------------
  // Interrupt condition detection
  // ----------------------------------------
  assign flags.primary_log_pending       = I_PRIMARY_LOG_PENDING;
  assign flags.advanced_log_first_record = I_ADVANCED_LOG_FIRST_RECORD;
  assign flags.inval_queue_error         = I_INVAL_QUEUE_ERROR;
  assign flags.bad_completion_flag       = I_BAD_COMPLETION_FLAG;
  assign flags.completion_timeout_flag   = I_COMPLETION_TIMEOUT_FLAG;
  assign flags.page_request_overflow     = I_PAGE_REQUEST_OVERFLOW;
  assign flags.advanced_fault_overflow   = I_ADVANCED_FAULT_OVERFLOW;
  assign flags.primary_fault_overflow    = I_PRIMARY_FAULT_OVERFLOW;

  always_comb
  begin
    cond_en                           = '0;
    cond_en.primary_log_pending       = !I_ADV_LOG_MODE;
    cond_en.advanced_log_first_record = I_ADV_LOG_MODE;
    cond_en.inval_queue_error         = 1'b1;
    cond_en.bad_completion_flag       = 1'b1;
    cond_en.completion_timeout_flag   = 1'b1;
    cond_en.page_request_overflow     = 1'b1;
  end

  // ----------------------------------------
  // Flag history, a flag already up hides later rises
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      flags_prev <= '0;
    else
      flags_prev <= flags;
  end

  assign flags_rise = flags & ~flags_prev;

  wire any_prev   = |flags_prev;
  wire new_cond   = |(flags_rise & cond_en) && !any_prev;
  wire all_served = ~|flags;

  // ----------------------------------------
  // Pending flag, set wins over clear
  // ----------------------------------------
  always_comb
  begin
    next_pending = pending_flag;
    if (msg_sent || all_served)
      next_pending = 1'b0;
    if (new_cond)
      next_pending = 1'b1;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      pending_flag <= 1'b0;
    else
      pending_flag <= next_pending;
  end

  // ----------------------------------------
  // Message sender
  // ----------------------------------------
  fei_msg u_msg
  (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RST),
    .i_pending (pending_flag),
    .i_mask    (event_mask_bit),
    .i_hold    (I_MSG_HOLD),
    .i_addr    (addr_view),
    .i_data    (data_view),
    .i_ready   (I_MSG_READY),
    .o_valid   (O_MSG_VALID),
    .o_addr    (O_MSG_ADDR),
    .o_data    (O_MSG_DATA),
    .o_sent    (msg_sent)
  );

  // ----------------------------------------
  // Top outputs
  // ----------------------------------------
  assign O_PENDING_FLAG   = pending_flag;
  assign O_EVENT_MASK_BIT = event_mask_bit;
endmodule

// ==== bench/fei_chk.sv ====
`timescale 1ns/1ps
module fei_chk
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST,
  input wire logic        I_ADV_LOG_MODE,
  input wire logic        I_PRIMARY_LOG_PENDING,
  input wire logic        I_ADVANCED_LOG_FIRST_RECORD,
  input wire logic        I_INVAL_QUEUE_ERROR,
  input wire logic        I_BAD_COMPLETION_FLAG,
  input wire logic        I_COMPLETION_TIMEOUT_FLAG,
  input wire logic        I_PAGE_REQUEST_OVERFLOW,
  input wire logic        I_ADVANCED_FAULT_OVERFLOW,
  input wire logic        I_PRIMARY_FAULT_OVERFLOW,
  input wire logic        I_MSG_HOLD,
  input wire logic        I_MSG_READY,
  input wire logic        O_MSG_VALID,
  input wire logic [31:0] O_MSG_ADDR,
  input wire logic [31:0] O_MSG_DATA,
  input wire logic        O_PENDING_FLAG,
  input wire logic        O_EVENT_MASK_BIT
);
  import fei_pkg::*;
  wire logic [7:0] flags = {I_PRIMARY_FAULT_OVERFLOW, I_ADVANCED_FAULT_OVERFLOW, I_PAGE_REQUEST_OVERFLOW,
                            I_COMPLETION_TIMEOUT_FLAG, I_BAD_COMPLETION_FLAG, I_INVAL_QUEUE_ERROR,
                            I_ADVANCED_LOG_FIRST_RECORD, I_PRIMARY_LOG_PENDING};
  wire logic       cond_src = (I_ADV_LOG_MODE ? I_ADVANCED_LOG_FIRST_RECORD : I_PRIMARY_LOG_PENDING) |
                              (|flags[5:2]);
  wire logic       any_flag = |flags;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  chk_reset_masked: assert property ($fell(I_RST) |-> O_EVENT_MASK_BIT && !O_PENDING_FLAG)
    else $error("mask or pending wrong after reset");
  chk_mask_quiet: assert property (O_EVENT_MASK_BIT |-> !O_MSG_VALID)
    else $error("message sent while masked");
  chk_cond_sets: assert property (!$past(any_flag) && cond_src |=> O_PENDING_FLAG)
    else $error("condition did not set pending");
  chk_no_new_cond: assert property (!O_PENDING_FLAG && $past(any_flag) |=> !O_PENDING_FLAG)
    else $error("pending set while a flag was already set");
  chk_valid_pending: assert property (O_MSG_VALID |-> O_PENDING_FLAG)
    else $error("message without pending");
  chk_hold_blocks: assert property (I_MSG_HOLD && !O_EVENT_MASK_BIT && !O_MSG_VALID |=> !O_MSG_VALID)
    else $error("message launched during hold");
  chk_send_clears: assert property (O_MSG_VALID && I_MSG_READY && $stable(flags) |=> !O_PENDING_FLAG)
    else $error("pending kept after message");
  chk_launch_due: assert property (O_PENDING_FLAG && !O_EVENT_MASK_BIT && !I_MSG_HOLD && !O_MSG_VALID
    |=> O_MSG_VALID || O_EVENT_MASK_BIT || !O_PENDING_FLAG)
    else $error("pending message not launched");
  chk_service_clear: assert property (O_PENDING_FLAG && !(|flags) |=> !O_PENDING_FLAG)
    else $error("pending kept after flags serviced");
  chk_msg_stable: assert property (O_MSG_VALID && !I_MSG_READY
    |=> !O_MSG_VALID || ($stable(O_MSG_ADDR) && $stable(O_MSG_DATA)))
    else $error("message changed while offered");
  chk_addr_align: assert property (O_MSG_VALID |-> O_MSG_ADDR[1:0] == 2'h0)
    else $error("message address not word aligned");
endmodule

// ==== bench/fei_fabric.sv ====
`timescale 1ns/1ps
module fei_fabric
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_valid,
  input  wire logic i_slow,
  output logic      o_ready
);
  // One-cycle accept pulse, sometimes late
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      o_ready <= 1'h0;
    else
      o_ready <= i_valid && !o_ready && (!i_slow || $urandom_range(3) == 0);
endmodule

// ==== bench/fei_top_tb.sv ====
`timescale 1ns/1ps
`include "fei_regs.svh"
module fei_top_tb;
  import fei_pkg::*;
  logic             clk, rst, awvalid, wvalid, bready, arvalid, rready, mode, hold, slow;
  logic [11:0]      awaddr, araddr;
  logic [31:0]      wdata, d, a;
  logic [7:0]       flg;
  logic [3:0]       strb;
  wire logic        awready, wready, bvalid, arready, rvalid, mvalid, mready, pend, mask;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata, maddr, mdata;
  logic [63:0]      qb[$], qr[$], qm[$];
  int               error_cnt, n_checks, msg_cnt, i;
  fei_top dut (.I_CORE_CLK(clk), .I_RST(rst), .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awvalid),
    .O_S_AXI_AWREADY(awready), .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(strb), .I_S_AXI_WVALID(wvalid),
    .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid), .I_S_AXI_BREADY(bready),
    .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arvalid), .O_S_AXI_ARREADY(arready), .O_S_AXI_RDATA(rdata),
    .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready), .I_ADV_LOG_MODE(mode),
    .I_PRIMARY_LOG_PENDING(flg[0]), .I_ADVANCED_LOG_FIRST_RECORD(flg[1]), .I_INVAL_QUEUE_ERROR(flg[2]),
    .I_BAD_COMPLETION_FLAG(flg[3]), .I_COMPLETION_TIMEOUT_FLAG(flg[4]), .I_PAGE_REQUEST_OVERFLOW(flg[5]),
    .I_ADVANCED_FAULT_OVERFLOW(flg[6]), .I_PRIMARY_FAULT_OVERFLOW(flg[7]), .I_MSG_HOLD(hold),
    .O_MSG_VALID(mvalid), .I_MSG_READY(mready), .O_MSG_ADDR(maddr), .O_MSG_DATA(mdata),
    .O_PENDING_FLAG(pend), .O_EVENT_MASK_BIT(mask));
  fei_fabric u_fab (.i_clk(clk), .i_rst(rst), .i_valid(mvalid), .i_slow(slow), .o_ready(mready));

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo;
    error_cnt++;
    close_out();
  endtask
  always @(posedge clk)
  begin
    if (!rst && bvalid && bready)
      cmp("bresp", qb.pop_front(), {62'h0, bresp});
    if (!rst && rvalid && rready)
      cmp("rdata", qr.pop_front(), {30'h0, rresp, rdata});
    if (!rst && mvalid && mready)
    begin
      cmp("message", qm.pop_front(), {maddr, mdata});
      msg_cnt++;
    end
  end

  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] ad, input logic [31:0] v, input logic [1:0] r);
    int k;
    qb.push_back({62'h0, r});
    @(posedge clk);
    awaddr <= ad;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      if (bvalid)
        break;
    end
    bready <= 1'h0;
    if (k == 100)
      tmo();
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] v, input logic [1:0] r);
    int k;
    qr.push_back({30'h0, r, v});
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
      if (rvalid)
        break;
    end
    rready <= 1'h0;
    if (k == 100)
      tmo();
  endtask
  task automatic wait_msg(input int n);
    int k;
    for (k = 0; k < 60 && msg_cnt < n; k++)
      @(posedge clk);
    if (msg_cnt < n)
      tmo();
  endtask
  task automatic raise(input int b);
    @(posedge clk);
    flg[b] <= 1'h1;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    rst <= 1'h1;
    {awvalid, wvalid, bready, arvalid, rready, mode, hold, slow} <= 8'h00;
    {awaddr, araddr, wdata, flg} <= 64'h0;
    strb <= 4'hF;
    void'($urandom(32311));
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rd(`FEI_CTL_OFS, 32'h8000_0000, `FEI_RESP_OKAY);
    rd(`FEI_DATA_OFS, `FEI_DATA_RST, `FEI_RESP_OKAY);
    wr(`FEI_CTL_OFS, 32'h7FFF_FFFF, `FEI_RESP_OKAY);
    rd(`FEI_CTL_OFS, 32'h0000_0000, `FEI_RESP_OKAY);
    wr(12'h100, $urandom, `FEI_RESP_SLVERR);
    rd(12'h100, 32'h0000_0000, `FEI_RESP_SLVERR);
    d = $urandom;
    a = $urandom;
    wr(`FEI_DATA_OFS, d, `FEI_RESP_OKAY);
    rd(`FEI_DATA_OFS, d, `FEI_RESP_OKAY);
    wr(`FEI_ADDR_OFS, a, `FEI_RESP_OKAY);
    rd(`FEI_ADDR_OFS, a & 32'hFFFF_FFFC, `FEI_RESP_OKAY);
    // Each condition source, in turn, sometimes held back
    for (i = 0; i < 6; i++)
    begin
      qm.push_back({a & 32'hFFFF_FFFC, d});
      @(posedge clk);
      mode <= (i == 1);
      hold <= 1'($urandom_range(1));
      slow <= 1'($urandom_range(1));
      raise(i);
      if (hold)
      begin
        cmp("pending", 64'h1, {63'h0, pend});
        cmp("sent", i, msg_cnt);
        @(posedge clk);
        hold <= 1'h0;
      end
      wait_msg(i + 1);
      @(negedge clk);
      cmp("pending", 64'h0, {63'h0, pend});
      @(posedge clk);
      flg <= 8'h00;
    end
    mode <= 1'h1;
    raise(0);
    cmp("pending", 64'h0, {63'h0, pend});
    @(posedge clk);
    flg <= 8'h40;
    raise(2);
    cmp("pending", 64'h0, {63'h0, pend});
    @(posedge clk);
    flg <= 8'h00;
    mode <= 1'h0;
    wr(`FEI_CTL_OFS, 32'h8000_0000, `FEI_RESP_OKAY);
    raise(5);
    repeat (8) @(negedge clk);
    cmp("sent", 6, msg_cnt);
    rd(`FEI_CTL_OFS, 32'hC000_0000, `FEI_RESP_OKAY);
    qm.push_back({a & 32'hFFFF_FFFC, d});
    wr(`FEI_CTL_OFS, 32'h0000_0000, `FEI_RESP_OKAY);
    wait_msg(7);
    flg <= 8'h00;
    wr(`FEI_CTL_OFS, 32'h8000_0000, `FEI_RESP_OKAY);
    strb <= 4'h7;
    wr(`FEI_CTL_OFS, 32'h0000_0000, `FEI_RESP_OKAY);
    strb <= 4'hF;
    cmp("mask", 64'h1, {63'h0, mask});
    for (i = 0; i < 8; i += 4)
    begin
      raise(i);
      cmp("pending", 64'h1, {63'h0, pend});
      @(posedge clk);
      flg <= 8'h00;
      repeat (3) @(negedge clk);
      cmp("pending", 64'h0, {63'h0, pend});
    end
    close_out();
  end
endmodule

bind fei_top fei_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_ADV_LOG_MODE(I_ADV_LOG_MODE),
  .I_PRIMARY_LOG_PENDING(I_PRIMARY_LOG_PENDING), .I_ADVANCED_LOG_FIRST_RECORD(I_ADVANCED_LOG_FIRST_RECORD),
  .I_INVAL_QUEUE_ERROR(I_INVAL_QUEUE_ERROR), .I_BAD_COMPLETION_FLAG(I_BAD_COMPLETION_FLAG),
  .I_COMPLETION_TIMEOUT_FLAG(I_COMPLETION_TIMEOUT_FLAG), .I_PAGE_REQUEST_OVERFLOW(I_PAGE_REQUEST_OVERFLOW),
  .I_ADVANCED_FAULT_OVERFLOW(I_ADVANCED_FAULT_OVERFLOW), .I_PRIMARY_FAULT_OVERFLOW(I_PRIMARY_FAULT_OVERFLOW),
  .I_MSG_HOLD(I_MSG_HOLD), .I_MSG_READY(I_MSG_READY), .O_MSG_VALID(O_MSG_VALID), .O_MSG_ADDR(O_MSG_ADDR),
  .O_MSG_DATA(O_MSG_DATA), .O_PENDING_FLAG(O_PENDING_FLAG), .O_EVENT_MASK_BIT(O_EVENT_MASK_BIT));
